// ---- core/hmbr_regs.sv ----
// Indexed extension register bank: mapping, burst, page, blit and DRAM config
// Function
// - Linear mapping only while linear enable set
// - Page enable exposes 64-KB page at A0000h
// - Seven-bit page number chooses window page
// - Burst writes accepted only while enabled
// - Depth bit zero eight, one four doublewords
// - Font override limits buffer to one doubleword while font expansion is active
// - Reserved bits read back as zero, except in DRAM access and type registers
// - Colour depth codes 8/16/24 bpp, reset 8
// - Control word bit 23 overrides depth
// - Depth sets bytes per pixel
// - Blit reset bit resets engine, clears zero
// - Status bit reads engine busy
// - Text organisation bit selects data layout
// - Wrap bit clear limits decode to 18 bits
// - Access width bit selects 16 or 64
// - DRAM type codes FPM or EDO
// - Registers reached via index then data port
// - Font override zero after reset
`timescale 1ns/1ps
module hmbr_regs
  import hmbr_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 index_wr,
  input  wire logic                 data_wr,
  input  wire logic                 data_rd,
  input  wire logic [7:0]           wdata,
  output logic      [7:0]           rdata,
  output logic      [7:0]           index_q,
  input  wire logic                 blit_busy,
  input  wire logic [31:0]          blit_control_word,
  input  wire logic                 font_exp_active,
  input  wire logic [19:0]          win_addr,
  input  wire logic [FB_ADDR_W-1:0] lin_addr,
  output logic                      win_hit,
  output logic                      lin_hit,
  output logic [FB_ADDR_W-1:0]      win_fb_addr,
  output logic [FB_ADDR_W-1:0]      lin_fb_addr,
  output logic                      burst_accept,
  output logic [3:0]                burst_depth_dw,
  output logic [1:0]                blit_depth,
  output logic [1:0]                blit_bytes_per_pixel,
  output logic                      blit_rst,
  output logic                      text_nonstd_org,
  output logic                      full_addr_decode,
  output logic                      mem_width_64,
  output logic [1:0]                dram_type
);
  logic [7:0] index_d;
  logic [7:0] fb_map_q,  fb_map_d;
  logic [7:0] burst_q,   burst_d;
  logic [7:0] page_q,    page_d;
  logic [7:0] blit_q,    blit_d;
  logic [7:0] dacc_q,    dacc_d;
  logic [7:0] dtype_q,   dtype_d;
  logic [7:0] rdata_d;
  logic       busy_q,    busy_d;

  // Next-state for index and bank
  always_comb begin
    index_d  = index_wr ? wdata : index_q;
    fb_map_d = fb_map_q;
    burst_d  = burst_q;
    page_d   = page_q;
    blit_d   = blit_q;
    dacc_d   = dacc_q;
    dtype_d  = dtype_q;
    busy_d   = blit_busy;
    if (data_wr) begin
      case (index_q)
        IDX_FB_MAP:    fb_map_d = wdata & FB_MAP_MASK;
        IDX_BURST:     burst_d  = wdata & BURST_MASK;
        IDX_PAGE_SEL:  page_d   = wdata & PAGE_SEL_MASK;
        IDX_BLIT_CFG:  blit_d   = wdata & BLIT_WR_MASK;
        // Writable reserved bits are stored as written; software keeps them zero
        IDX_DRAM_ACC:  dacc_d   = wdata;
        IDX_DRAM_TYPE: dtype_d  = wdata;
        default: ;
      endcase
    end
  end

  // Read mux; registered so data comes from flip-flops
  always_comb begin
    case (index_q)
      IDX_FB_MAP:    rdata_d = fb_map_q;
      IDX_BURST:     rdata_d = burst_q;
      IDX_PAGE_SEL:  rdata_d = page_q;
      IDX_BLIT_CFG:  rdata_d = {blit_q[7:1], busy_q};
      IDX_DRAM_ACC:  rdata_d = dacc_q;
      IDX_DRAM_TYPE: rdata_d = dtype_q;
      default:       rdata_d = RST_BYTE;
    endcase
    if (!data_rd) begin
      rdata_d = rdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      index_q <= RST_BYTE;
      fb_map_q <= RST_BYTE;
      burst_q  <= RST_BYTE;
      page_q   <= RST_BYTE;
      blit_q   <= RST_BYTE;
      dacc_q   <= RST_BYTE;
      dtype_q  <= RST_BYTE;
      busy_q   <= 1'b0;
      rdata    <= RST_BYTE;
    end else begin
      index_q <= index_d;
      fb_map_q <= fb_map_d;
      burst_q  <= burst_d;
      page_q   <= page_d;
      blit_q   <= blit_d;
      dacc_q   <= dacc_d;
      dtype_q  <= dtype_d;
      busy_q   <= busy_d;
      rdata    <= rdata_d;
    end
  end

  // Burst buffer controls
  always_comb begin
    burst_accept = burst_q[BW_EN_BIT];
    if (burst_q[BW_FONT_BIT] && font_exp_active) begin
      burst_depth_dw = BURST_DW_1;
    end else if (burst_q[BW_DEPTH_BIT]) begin
      burst_depth_dw = BURST_DW_4;
    end else begin
      burst_depth_dw = BURST_DW_8;
    end
  end

  assign text_nonstd_org  = dacc_q[DA_TEXT_BIT];
  assign full_addr_decode = dacc_q[DA_WRAP_BIT];
  assign mem_width_64     = dacc_q[DA_WIDTH_BIT];
  assign dram_type        = dtype_q[1:0];

  hmbr_blit_cfg u_blit (
    .cfg_depth         (blit_q[BLIT_DEPTH_LSB +: 2]),
    .cfg_reset         (blit_q[BLIT_RST_BIT]),
    .blit_control_word (blit_control_word),
    .eff_depth         (blit_depth),
    .bytes_per_pixel   (blit_bytes_per_pixel),
    .blit_rst_hold     (blit_rst)
  );

  // Page number only matters while page enable is set by software
  hmbr_addr_map u_map (
    .win_addr    (win_addr),
    .lin_addr    (lin_addr),
    .page_en     (fb_map_q[FB_PAGE_EN_BIT]),
    .lin_en      (fb_map_q[FB_LIN_EN_BIT]),
    .page_num    (page_q[6:0]),
    .full_addr   (dacc_q[DA_WRAP_BIT]),
    .win_hit     (win_hit),
    .lin_hit     (lin_hit),
    .win_fb_addr (win_fb_addr),
    .lin_fb_addr (lin_fb_addr)
  );
endmodule // hmbr_regs

// ---- core/hmbr_pkg.sv ----
// Register indices, field positions and reset values of the mapping/blit/DRAM config bank
package hmbr_pkg;
  localparam logic [7:0] IDX_FB_MAP      = 8'h0A;
  localparam logic [7:0] IDX_BURST       = 8'h0B;
  localparam logic [7:0] IDX_PAGE_SEL    = 8'h0E;
  localparam logic [7:0] IDX_BLIT_CFG    = 8'h20;
  localparam logic [7:0] IDX_DRAM_ACC    = 8'h40;
  localparam logic [7:0] IDX_DRAM_TYPE   = 8'h41;

  localparam int FB_PAGE_EN_BIT   = 0;
  localparam int FB_LIN_EN_BIT    = 1;
  localparam logic [7:0] FB_MAP_MASK    = 8'h03;
  localparam int BW_EN_BIT        = 0;
  localparam int BW_DEPTH_BIT     = 2;
  localparam int BW_FONT_BIT      = 3;
  localparam logic [7:0] BURST_MASK     = 8'h0D;
  localparam logic [7:0] PAGE_SEL_MASK  = 8'h7F;
  localparam int BLIT_STAT_BIT    = 0;
  localparam int BLIT_RST_BIT     = 1;
  localparam int BLIT_DEPTH_LSB   = 4;
  localparam logic [7:0] BLIT_WR_MASK   = 8'h32;
  localparam int DA_WIDTH_BIT     = 0;
  localparam int DA_WRAP_BIT      = 1;
  localparam int DA_TEXT_BIT      = 4;
  localparam int CTRL_OVR_BIT     = 23;
  localparam int CTRL_DEPTH_LSB   = 24;

  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [1:0] DEPTH_8BPP     = 2'h0;
  localparam logic [1:0] DEPTH_16BPP    = 2'h1;
  localparam logic [1:0] DEPTH_24BPP    = 2'h2;
  localparam logic [1:0] DRAM_FPM       = 2'h0;
  localparam logic [1:0] DRAM_EDO       = 2'h1;

  localparam logic [3:0] BURST_DW_8     = 4'h8;
  localparam logic [3:0] BURST_DW_4     = 4'h4;
  localparam logic [3:0] BURST_DW_1     = 4'h1;

  localparam int PAGE_SHIFT       = 16;
  localparam int FB_ADDR_W        = 22;
  localparam int WRAP_ADDR_W      = 18;
  localparam logic [19:0] WIN_BASE      = 20'hA0000;
  localparam logic [19:0] WIN_LAST      = 20'hAFFFF;
endpackage

// ---- core/hmbr_blit_cfg.sv ----
// Effective blit colour depth, bytes per pixel and held engine reset
`timescale 1ns/1ps
module hmbr_blit_cfg
  import hmbr_pkg::*;
(
  input  wire logic [1:0]  cfg_depth,
  input  wire logic        cfg_reset,
  input  wire logic [31:0] blit_control_word,
  output logic      [1:0]  eff_depth,
  output logic      [1:0]  bytes_per_pixel,
  output logic             blit_rst_hold
);
  always_comb begin
    eff_depth = blit_control_word[CTRL_OVR_BIT] ?
                blit_control_word[CTRL_DEPTH_LSB +: 2] : cfg_depth;
    case (eff_depth)
      DEPTH_8BPP:  bytes_per_pixel = 2'h1;
      DEPTH_16BPP: bytes_per_pixel = 2'h2;
      DEPTH_24BPP: bytes_per_pixel = 2'h3;
      default:     bytes_per_pixel = 2'h1;
    endcase
  end

  // Engine stays in reset as long as the control bit is set
  assign blit_rst_hold = cfg_reset;
endmodule // hmbr_blit_cfg

// ---- core/hmbr_addr_map.sv ----
// Host address decode for legacy window and linear paths with wrap
`timescale 1ns/1ps
module hmbr_addr_map
  import hmbr_pkg::*;
(
  input  wire logic [19:0]          win_addr,
  input  wire logic [FB_ADDR_W-1:0] lin_addr,
  input  wire logic                 page_en,
  input  wire logic                 lin_en,
  input  wire logic [6:0]           page_num,
  input  wire logic                 full_addr,
  output logic                      win_hit,
  output logic                      lin_hit,
  output logic [FB_ADDR_W-1:0]      win_fb_addr,
  output logic [FB_ADDR_W-1:0]      lin_fb_addr
);
  function automatic logic [FB_ADDR_W-1:0] wrap_addr(input logic [FB_ADDR_W-1:0] a,
                                                     input logic full);
    wrap_addr = full ? a : {{(FB_ADDR_W-WRAP_ADDR_W){1'b0}}, a[WRAP_ADDR_W-1:0]};
  endfunction

  logic [28:0] win_full;
  always_comb begin
    win_hit  = page_en && (win_addr >= WIN_BASE) && (win_addr <= WIN_LAST);
    lin_hit  = lin_en;
    win_full = ({22'h0, page_num} << PAGE_SHIFT) + {13'h0, win_addr[15:0]};
    win_fb_addr = wrap_addr(win_full[FB_ADDR_W-1:0], full_addr);
    lin_fb_addr = wrap_addr(lin_addr, full_addr);
  end
endmodule // hmbr_addr_map

// ---- sim/hmbr_monitor.sv ----
// Port-level checks bound onto the config register bank
`timescale 1ns/1ps
module hmbr_monitor
  import hmbr_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        index_wr,
  input wire logic        data_wr,
  input wire logic        data_rd,
  input wire logic [7:0]  wdata,
  input wire logic [7:0]  rdata,
  input wire logic [7:0]  index_q,
  input wire logic [31:0] blit_control_word,
  input wire logic        font_exp_active,
  input wire logic [19:0] win_addr,
  input wire logic        win_hit,
  input wire logic [21:0] win_fb_addr,
  input wire logic        full_addr_decode,
  input wire logic [3:0]  burst_depth_dw,
  input wire logic [1:0]  blit_depth,
  input wire logic [1:0]  blit_bytes_per_pixel,
  input wire logic        blit_rst,
  input wire logic [1:0]  dram_type
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  index_load_a: assert property (index_wr |=> index_q == $past(wdata))
    else $error("index not loaded");
  rdata_hold_a: assert property (!data_rd |=> $stable(rdata))
    else $error("read data moved");
  win_range_a: assert property (win_hit |-> win_addr[19:16] == 4'hA)
    else $error("window hit outside window");
  win_offset_a: assert property (win_hit |-> win_fb_addr[15:0] == win_addr[15:0])
    else $error("window offset lost");
  addr_wrap_a: assert property (!full_addr_decode |-> win_fb_addr[21:18] == 4'h0)
    else $error("address not wrapped");
  depth_ovr_a: assert property (
    blit_control_word[23] |-> blit_depth == blit_control_word[25:24])
    else $error("override depth ignored");
  bpp_map_a: assert property (
    blit_bytes_per_pixel == (blit_depth == 2'h1 ? 2'h2 : blit_depth == 2'h2 ? 2'h3 : 2'h1))
    else $error("bytes per pixel wrong");
  burst_dw_a: assert property (!font_exp_active |-> burst_depth_dw inside {4'h4, 4'h8})
    else $error("burst depth wrong");
  cfg_hold_a: assert property (!data_wr |=> $stable({blit_rst, dram_type}))
    else $error("config moved without write");
  cover property (index_wr ##1 data_wr);
  cover property (font_exp_active && burst_depth_dw == 4'h1);
  cover property (win_hit && blit_control_word[23]);
endmodule // hmbr_monitor
bind hmbr_regs hmbr_monitor mon_u (.*);

// ---- sim/hmbr_host_model.sv ----
// Host CPU model: index port then data port cycles
`timescale 1ns/1ps
module hmbr_host_model (
  input  wire logic       clk,
  output logic            index_wr,
  output logic            data_wr,
  output logic            data_rd,
  output logic [7:0]      wdata,
  input  wire logic [7:0] rdata
);
  initial begin
    index_wr = 1'b0;
    data_wr = 1'b0;
    data_rd = 1'b0;
    wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    @(posedge clk);
    index_wr <= 1'b1;
    wdata <= idx;
    @(posedge clk);
    index_wr <= 1'b0;
    data_wr <= 1'b1;
    wdata <= v;
    @(posedge clk);
    data_wr <= 1'b0;
    wdata <= ~v; // Idle bus carries no stale value
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] v);
    @(posedge clk);
    index_wr <= 1'b1;
    wdata <= idx;
    @(posedge clk);
    index_wr <= 1'b0;
    data_rd <= 1'b1;
    wdata <= ~idx;
    @(posedge clk);
    data_rd <= 1'b0;
    #1 v = rdata;
  endtask
endmodule // hmbr_host_model

// ---- sim/tb_host_mapping_blit_dram_config_regs.sv ----
// Self-checking bench for the config register bank
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb_host_mapping_blit_dram_config_regs
  import hmbr_pkg::*;
;
  logic        clk, rst_b, index_wr, data_wr, data_rd, blit_busy, font_exp_active;
  logic        win_hit, lin_hit, burst_accept, blit_rst;
  logic        text_nonstd_org, full_addr_decode, mem_width_64;
  logic [7:0]  wdata, rdata, index_q, r, v;
  logic [31:0] blit_control_word;
  logic [19:0] win_addr;
  logic [21:0] lin_addr, win_fb_addr, lin_fb_addr;
  logic [3:0]  burst_depth_dw;
  logic [1:0]  blit_depth, blit_bytes_per_pixel, dram_type;
  logic [7:0]  sh [7];
  logic [7:0]  idx [7] = '{IDX_FB_MAP, IDX_BURST, IDX_PAGE_SEL, IDX_BLIT_CFG,
                           IDX_DRAM_ACC, IDX_DRAM_TYPE, 8'h55};
  logic [7:0]  rm [7] = '{FB_MAP_MASK, BURST_MASK, PAGE_SEL_MASK, BLIT_WR_MASK,
                          8'hFF, 8'hFF, 8'h00};
  logic [7:0]  wm [7] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h13, 8'h03, 8'hFF};
  int          error_cnt, n_compared, k, seed;
  hmbr_regs dut_u (.*);
  hmbr_host_model host_u (.*);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [21:0] wrap(input logic [21:0] a);
    return sh[4][DA_WRAP_BIT] ? a : a & 22'h03FFFF;
  endfunction
  // Font override only bites while expansion runs; otherwise the depth bit rules
  function automatic logic [3:0] exp_burst(input logic [7:0] b, input logic font);
    return (b[BW_FONT_BIT] && font) ? BURST_DW_1 :
           b[BW_DEPTH_BIT] ? BURST_DW_4 : BURST_DW_8;
  endfunction
  function automatic logic [1:0] exp_bpp(input logic [1:0] d);
    return d == DEPTH_16BPP ? 2'h2 : d == DEPTH_24BPP ? 2'h3 : 2'h1;
  endfunction
  task automatic finish_test();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check_outputs();
    logic [1:0] d;
    d = blit_control_word[23] ? blit_control_word[25:24] : sh[3][5:4];
    `CHK(burst_accept, sh[1][BW_EN_BIT])
    `CHK(burst_depth_dw, exp_burst(sh[1], font_exp_active))
    `CHK(lin_hit, sh[0][FB_LIN_EN_BIT])
    `CHK(win_hit, sh[0][FB_PAGE_EN_BIT] && win_addr[19:16] == 4'hA)
    `CHK(win_fb_addr, wrap(22'({sh[2][6:0], win_addr[15:0]})))
    `CHK(lin_fb_addr, wrap(lin_addr))
    `CHK(blit_depth, d)
    `CHK(blit_bytes_per_pixel, exp_bpp(d))
    `CHK(blit_rst, sh[3][BLIT_RST_BIT])
    `CHK({text_nonstd_org, full_addr_decode, mem_width_64}, {sh[4][4], sh[4][1:0]})
    `CHK(dram_type, sh[5][1:0])
  endtask
  initial begin
    #(5000 * 100);
    error_cnt++;
    finish_test();
  end
  initial begin
    seed = 32'h1ed92952;
    rst_b = 1'b0;
    blit_busy = 1'b0;
    font_exp_active = 1'b0;
    blit_control_word = 32'h0;
    win_addr = 20'h0;
    lin_addr = 22'h0;
    sh = '{default: 8'h00};
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    for (k = 0; k < 7; k++) begin
      host_u.rd(idx[k], r);
      `CHK(r, 8'h00)
    end
    @(posedge clk);
    blit_busy <= 1'b1;
    host_u.rd(IDX_BLIT_CFG, r);
    `CHK(r[BLIT_STAT_BIT], 1'b1)
    @(posedge clk);
    blit_busy <= 1'b0;
    repeat (2) @(posedge clk);
    repeat (80) begin
      k = $unsigned($random(seed)) % 7;
      v = 8'($random(seed)) & wm[k];
      host_u.wr(idx[k], v);
      sh[k] = v & rm[k];
      host_u.rd(idx[k], r);
      `CHK(r, sh[k])
      @(posedge clk);
      font_exp_active <= 1'($random(seed));
      blit_control_word <= $random(seed);
      win_addr <= {($random(seed) & 1) ? 4'hA : 4'h9, 16'($random(seed))};
      lin_addr <= 22'($random(seed));
      @(posedge clk);
      #1 check_outputs();
    end
    finish_test();
  end
endmodule // tb_host_mapping_blit_dram_config_regs
